/* File: rtl/halfband_interp_stage_config.sv */
// Three-stage half-band interpolation chain with AXI4-Lite control.
// Assumes one clock, synchronous active-low reset, clock enable ce.
`timescale 1ns/1ps
`include "halfband_map.svh"

module sample_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 8,
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic ce, // Clock enable
  input wire logic in_valid, // Write side valid
  output logic in_ready, // Write side ready
  input wire logic [W-1:0] in_data, // Write data
  output logic out_valid, // Read side valid
  input wire logic out_ready, // Read side ready
  output logic [W-1:0] out_data, // Read data
  output logic [CW-1:0] count // Words held
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic push;
  logic pop;

  function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
    if (p == PW'(DEPTH - 1)) begin
      return '0;
    end
    return p + PW'(1);
  endfunction

  assign in_ready = ce && (count_reg != CW'(DEPTH));
  assign out_valid = count_reg != '0;
  assign out_data = mem[rd_ptr_reg];
  assign count = count_reg;
  assign push = in_valid && in_ready;
  assign pop = ce && out_valid && out_ready;

  always_ff @(posedge aclk) begin
    if (ce && push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (ce) begin
      if (push) begin
        wr_ptr_reg <= next_ptr(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= next_ptr(rd_ptr_reg);
      end
      if (push && !pop) begin
        count_reg <= count_reg + CW'(1);
      end else if (pop && !push) begin
        count_reg <= count_reg - CW'(1);
      end
    end
  end
endmodule

module halfband_stage #(
  parameter int DATA_W = 16
) (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic ce, // Clock enable
  input wire logic bypass, // Stage removed from path
  input halfband_pkg::mode_sel_t sel, // Decoded mode
  input wire logic in_valid, // Input sample valid
  output logic in_ready, // Input sample taken
  input wire logic signed [DATA_W-1:0] in_data, // Input sample
  output logic out_valid, // Output sample valid
  input wire logic out_ready, // Output sample taken
  output logic signed [DATA_W-1:0] out_data // Output sample
);
  import halfband_pkg::*;
  phase_t ph_reg;
  logic signed [DATA_W-1:0] prev_reg;
  logic signed [DATA_W-1:0] cur_reg;
  logic signed [DATA_W-1:0] out_reg;
  logic signed [DATA_W:0] sum;
  logic signed [DATA_W-1:0] half;
  logic take;

  // Midpoint sample between previous and new input
  assign sum = {prev_reg[DATA_W-1], prev_reg} + {in_data[DATA_W-1], in_data};
  assign half = sum[DATA_W:1];
  assign in_ready = ce && (ph_reg == PH_IDLE ||
                           (ph_reg == PH_ORIG && out_ready));
  assign take = in_valid && in_ready;
  assign out_valid = ph_reg != PH_IDLE;
  assign out_data = out_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ph_reg <= PH_IDLE;
    end else if (ce) begin
      case (ph_reg)
        PH_IDLE: begin
          if (take) begin
            ph_reg <= bypass ? PH_ORIG : PH_INTERP;
          end
        end
        PH_INTERP: begin
          if (out_ready) begin
            ph_reg <= PH_ORIG;
          end
        end
        PH_ORIG: begin
          if (take) begin
            ph_reg <= bypass ? PH_ORIG : PH_INTERP;
          end else if (out_ready) begin
            ph_reg <= PH_IDLE;
          end
        end
        default: ph_reg <= PH_IDLE;
      endcase
    end
  end

  // Two outputs per input when active: midpoint, then original
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_reg <= '0;
      cur_reg <= '0;
      out_reg <= '0;
    end else if (ce) begin
      if (take) begin
        prev_reg <= in_data;
        // Shift by input rate flips every second output sample
        cur_reg <= sel.shift ? -in_data : in_data;
        if (bypass) begin
          out_reg <= in_data;
        end else begin
          out_reg <= sel.upper ? -half : half;
        end
      end else if (ph_reg == PH_INTERP && out_ready) begin
        out_reg <= cur_reg;
      end
    end
  end

  sequence s_take_active;
    ce && take && !bypass;
  endsequence
  property p_bypass_pass;
    @(posedge aclk) disable iff (!aresetn)
    ce && take && bypass |=> out_valid && out_data == $past(in_data);
  endproperty
  a_bypass_pass: assert property (p_bypass_pass)
    else $error("bypassed stage altered sample");
  property p_active_two;
    @(posedge aclk) disable iff (!aresetn)
    s_take_active |=> out_valid && ph_reg == PH_INTERP;
  endproperty
  a_active_two: assert property (p_active_two)
    else $error("active stage did not start two-sample output");
  property p_shift_odd;
    @(posedge aclk) disable iff (!aresetn)
    s_take_active ##0 sel.shift |=>
      cur_reg == DATA_W'(-$past(in_data));
  endproperty
  a_shift_odd: assert property (p_shift_odd)
    else $error("shifted mode did not invert odd sample");
endmodule

module halfband_interp_stage_config #(
  parameter int DATA_W = 16,
  parameter int FIFO_DEPTH = 8,
  parameter logic [7:0] PART_ID = 8'h5A // Arbitrary value
) (
  input wire logic aclk, // Clock, 20 MHz
  input wire logic aresetn, // Sync reset, active low
  input wire logic ce, // Clock enable
  input wire logic [9:0] s_axi_awaddr, // Write address
  input wire logic [2:0] s_axi_awprot, // Unused
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [9:0] s_axi_araddr, // Read address
  input wire logic [2:0] s_axi_arprot, // Unused
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic sample_in_valid, // Input sample valid
  output logic sample_in_ready, // Input sample taken
  input wire logic [DATA_W-1:0] sample_in_data, // Input sample
  output logic sample_out_valid, // Output sample valid
  input wire logic sample_out_ready, // Output sample taken
  output logic [DATA_W-1:0] sample_out_data // Output sample
);
  import halfband_pkg::*;
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  logic [7:0] first_halfband_control_reg;
  logic [7:0] second_halfband_control_reg;
  logic [7:0] third_halfband_control_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awidx_reg;
  logic [7:0] wdata_reg;
  logic wstrb0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic aw_hs;
  logic w_hs;
  logic do_write;
  logic [7:0] wr_idx;
  logic [7:0] wr_data;
  logic wr_en0;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic [1:0] first_stage_mode;
  logic [5:0] second_stage_mode;
  logic [5:0] third_stage_mode;
  mode_sel_t sel1;
  mode_sel_t sel2;
  mode_sel_t sel3;
  logic [CW-1:0] fifo_count;
  logic [1:0] active_count;
  logic f_valid;
  logic f_ready;
  logic [DATA_W-1:0] f_data;
  logic v1;
  logic r1;
  logic [DATA_W-1:0] d1;
  logic v2;
  logic r2;
  logic [DATA_W-1:0] d2;

  // Mode codes in groups of eight; top bit shifts, low bit picks upper band
  function automatic mode_sel_t decode_mode(input logic [2:0] grp);
    mode_sel_t s;
    s.shift = grp[2];
    s.upper = grp[0];
    return s;
  endfunction

  assign first_stage_mode =
    first_halfband_control_reg[`MODE1_HI:`MODE1_LO];
  assign second_stage_mode =
    second_halfband_control_reg[`MODE6_HI:`MODE6_LO];
  assign third_stage_mode =
    third_halfband_control_reg[`MODE6_HI:`MODE6_LO];
  assign sel1 = decode_mode({first_stage_mode[1], 1'b0,
                             first_stage_mode[0]});
  // Only the upper three bits select, so unlisted codes fall to a neighbour
  assign sel2 = decode_mode(second_stage_mode[5:3]);
  assign sel3 = decode_mode(third_stage_mode[5:3]);
  assign active_count = 2'(!first_halfband_control_reg[`BYPASS_BIT]) +
                        2'(!second_halfband_control_reg[`BYPASS_BIT]) +
                        2'(!third_halfband_control_reg[`BYPASS_BIT]);

  // Write channel: address and data taken in either order
  assign s_axi_awready = ce && !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = ce && !w_held_reg && !bvalid_reg;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign do_write = (aw_held_reg || aw_hs) && (w_held_reg || w_hs);
  assign wr_idx = aw_hs ? s_axi_awaddr[9:2] : awidx_reg;
  assign wr_data = w_hs ? s_axi_wdata[7:0] : wdata_reg;
  assign wr_en0 = w_hs ? s_axi_wstrb[0] : wstrb0_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awidx_reg <= '0;
      wdata_reg <= '0;
      wstrb0_reg <= 1'b0;
    end else if (ce) begin
      if (aw_hs) begin
        awidx_reg <= s_axi_awaddr[9:2];
      end
      if (w_hs) begin
        wdata_reg <= s_axi_wdata[7:0];
        wstrb0_reg <= s_axi_wstrb[0];
      end
      aw_held_reg <= (aw_held_reg || aw_hs) && !do_write;
      w_held_reg <= (w_held_reg || w_hs) && !do_write;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
    end else if (ce) begin
      if (do_write) begin
        bvalid_reg <= 1'b1;
        if (wr_idx >= `IDX_FIRST_CTRL && wr_idx <= `IDX_STATUS) begin
          bresp_reg <= `RESP_OKAY;
        end else begin
          bresp_reg <= `RESP_DECERR;
        end
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Identification and status words ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_halfband_control_reg <= `CTRL_RESET;
      second_halfband_control_reg <= `CTRL_RESET;
      third_halfband_control_reg <= `CTRL_RESET;
    end else if (ce && do_write && wr_en0) begin
      if (wr_idx == `IDX_FIRST_CTRL) begin
        first_halfband_control_reg <= wr_data;
      end else if (wr_idx == `IDX_SECOND_CTRL) begin
        second_halfband_control_reg <= wr_data;
      end else if (wr_idx == `IDX_THIRD_CTRL) begin
        third_halfband_control_reg <= wr_data;
      end
    end
  end

  // Read channel
  assign s_axi_arready = ce && !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    if (s_axi_araddr[9:2] == `IDX_FIRST_CTRL) begin
      rd_mux[7:0] = first_halfband_control_reg;
    end else if (s_axi_araddr[9:2] == `IDX_SECOND_CTRL) begin
      rd_mux[7:0] = second_halfband_control_reg;
    end else if (s_axi_araddr[9:2] == `IDX_THIRD_CTRL) begin
      rd_mux[7:0] = third_halfband_control_reg;
    end else if (s_axi_araddr[9:2] == `IDX_PART_ID) begin
      rd_mux[7:0] = PART_ID;
    end else if (s_axi_araddr[9:2] == `IDX_STATUS) begin
      rd_mux[CW+1:0] = {fifo_count, active_count};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= `RESP_OKAY;
      rdata_reg <= '0;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_mux;
        rresp_reg <= rd_hit ? `RESP_OKAY : `RESP_DECERR;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // Sample path: FIFO, then the three stages in series
  sample_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH), .CW(CW)) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .in_valid(sample_in_valid),
    .in_ready(sample_in_ready),
    .in_data(sample_in_data),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data),
    .count(fifo_count)
  );

  halfband_stage #(.DATA_W(DATA_W)) u_first (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .bypass(first_halfband_control_reg[`BYPASS_BIT]),
    .sel(sel1),
    .in_valid(f_valid),
    .in_ready(f_ready),
    .in_data(f_data),
    .out_valid(v1),
    .out_ready(r1),
    .out_data(d1)
  );

  halfband_stage #(.DATA_W(DATA_W)) u_second (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .bypass(second_halfband_control_reg[`BYPASS_BIT]),
    .sel(sel2),
    .in_valid(v1),
    .in_ready(r1),
    .in_data(d1),
    .out_valid(v2),
    .out_ready(r2),
    .out_data(d2)
  );

  halfband_stage #(.DATA_W(DATA_W)) u_third (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .bypass(third_halfband_control_reg[`BYPASS_BIT]),
    .sel(sel3),
    .in_valid(v2),
    .in_ready(r2),
    .in_data(d2),
    .out_valid(sample_out_valid),
    .out_ready(sample_out_ready),
    .out_data(sample_out_data)
  );

  sequence s_wr_idx(logic [7:0] idx);
    ce && do_write && wr_en0 && wr_idx == idx;
  endsequence
  property p_first_mode;
    @(posedge aclk) disable iff (!aresetn)
    s_wr_idx(`IDX_FIRST_CTRL) |=> first_stage_mode == $past(wr_data[2:1]);
  endproperty
  a_first_mode: assert property (p_first_mode)
    else $error("first stage mode not taken from bits 2:1");
  property p_first_bypass;
    @(posedge aclk) disable iff (!aresetn)
    s_wr_idx(`IDX_FIRST_CTRL) |=>
      u_first.bypass == $past(wr_data[0]);
  endproperty
  a_first_bypass: assert property (p_first_bypass)
    else $error("first stage bypass not taken from bit 0");
  property p_second_mode;
    @(posedge aclk) disable iff (!aresetn)
    s_wr_idx(`IDX_SECOND_CTRL) |=>
      sel2.shift == $past(wr_data[6]) && sel2.upper == $past(wr_data[4]);
  endproperty
  a_second_mode: assert property (p_second_mode)
    else $error("second stage mode decode wrong");
  property p_second_bypass;
    @(posedge aclk) disable iff (!aresetn)
    s_wr_idx(`IDX_SECOND_CTRL) |=> u_second.bypass == $past(wr_data[0]);
  endproperty
  a_second_bypass: assert property (p_second_bypass)
    else $error("second stage bypass not taken from bit 0");
  property p_third_mode;
    @(posedge aclk) disable iff (!aresetn)
    s_wr_idx(`IDX_THIRD_CTRL) |=>
      third_stage_mode == $past(wr_data[6:1]);
  endproperty
  a_third_mode: assert property (p_third_mode)
    else $error("third stage mode not taken from bits 6:1");
  property p_third_bypass;
    @(posedge aclk) disable iff (!aresetn)
    s_wr_idx(`IDX_THIRD_CTRL) |=> u_third.bypass == $past(wr_data[0]);
  endproperty
  a_third_bypass: assert property (p_third_bypass)
    else $error("third stage bypass not taken from bit 0");
  property p_id_read;
    @(posedge aclk) disable iff (!aresetn)
    ce && s_axi_arvalid && s_axi_arready &&
      s_axi_araddr[9:2] == `IDX_PART_ID |=>
      s_axi_rvalid && s_axi_rdata == {24'h000000, PART_ID};
  endproperty
  a_id_read: assert property (p_id_read)
    else $error("identification read returned wrong value");
endmodule

/* File: rtl/halfband_map.svh */
// Register indices, field positions and reset values of the half-band
// configuration block. Byte address on the bus is four times the index.
`ifndef HALFBAND_MAP_SVH
`define HALFBAND_MAP_SVH
`define IDX_FIRST_CTRL 8'h1C
`define IDX_SECOND_CTRL 8'h1D
`define IDX_THIRD_CTRL 8'h1E
`define IDX_PART_ID 8'h1F
`define IDX_STATUS 8'h20
`define CTRL_RESET 8'h00
`define BYPASS_BIT 0
`define MODE1_HI 2
`define MODE1_LO 1
`define MODE6_HI 6
`define MODE6_LO 1
`define RESP_OKAY 2'b00
`define RESP_DECERR 2'b11
`endif

/* File: rtl/halfband_pkg.sv */
// Types shared by the half-band configuration block.
// Assumes the map header supplies the numeric constants.
package halfband_pkg;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_INTERP = 2'b01,
    PH_ORIG = 2'b10
  } phase_t;
  typedef struct packed {
    logic shift;
    logic upper;
  } mode_sel_t;
endpackage

/* File: verification/tb.sv */
// Self-checking bench for the half-band configuration block.
// Assumes the rtl/ package, header and design files are compiled first.
`timescale 1ns/1ps
`include "halfband_map.svh"

module tb;
  import halfband_pkg::*;
  localparam logic [7:0] ID_CODE = 8'hA6; // Arbitrary value
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [9:0] awaddr = 10'h000, araddr = 10'h000;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, in_ready, out_valid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic in_valid = 1'b0, out_ready = 1'b0;
  logic [15:0] in_data = 16'h0000;
  logic [15:0] out_data;
  int n_errors = 0;
  int samples_checked = 0;
  logic [15:0] prev [3];
  logic [2:0] byp, sh, up;
  logic [15:0] expq [$];

  halfband_interp_stage_config #(.DATA_W(16), .FIFO_DEPTH(8),
      .PART_ID(ID_CODE)) u_halfband_interp_stage_config (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awprot(awprot),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(arprot),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sample_in_valid(in_valid),
    .sample_in_ready(in_ready), .sample_in_data(in_data),
    .sample_out_valid(out_valid), .sample_out_ready(out_ready),
    .sample_out_data(out_data)
  );

  initial begin
    forever #25 aclk = ~aclk;
  end

  task automatic close_out();
    $display("checked %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk_bus(input string n, input logic [31:0] e,
      input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_smp(input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR sample_out_data expected %h seen %h", e, g);
    end
  endtask

  function automatic logic [9:0] ba(input logic [7:0] i);
    return {i, 2'b00};
  endfunction

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    prev = '{16'h0000, 16'h0000, 16'h0000};
    expq = {};
  endtask

  // Address and data offered together; each released once taken
  task automatic wr(input logic [9:0] a, input logic [31:0] d,
      input logic [3:0] s, input logic [1:0] er);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    awprot <= 3'($urandom);
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    chk_bus("bresp", {30'h0, er}, {30'h0, bresp});
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input string n, input logic [9:0] a,
      input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arprot <= 3'($urandom);
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    chk_bus(n, ed, rdata);
    chk_bus("rresp", {30'h0, er}, {30'h0, rresp});
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Reference chain: midpoint then sample per active stage
  task automatic model_in(input logic [15:0] x);
    logic [15:0] q [$];
    logic [15:0] n [$];
    logic [16:0] s;
    logic [15:0] m;
    q = {x};
    for (int st = 0; st < 3; st++) begin
      n = {};
      foreach (q[i]) begin
        if (byp[st]) begin
          n.push_back(q[i]);
        end else begin
          s = {prev[st][15], prev[st]} + {q[i][15], q[i]};
          m = s[16:1];
          n.push_back(up[st] ? -m : m);
          n.push_back(sh[st] ? -q[i] : q[i]);
          prev[st] = q[i];
        end
      end
      q = n;
    end
    foreach (q[i]) expq.push_back(q[i]);
  endtask

  // Multiples of eight keep every midpoint exact through three stages
  task automatic stream(input int cnt, input int busy);
    logic pdone;
    pdone = (cnt == 0);
    fork
      begin
        for (int i = 0; i < cnt; i++) begin
          in_valid <= 1'b1;
          in_data <= 16'($urandom) & 16'hFFF8;
          do @(posedge aclk); while (!in_ready);
          model_in(in_data);
        end
        in_valid <= 1'b0;
        pdone = 1'b1;
      end
      begin
        for (int c = 0; !(pdone && expq.size() == 0); c++) begin
          if (c > 4000) begin
            n_errors++;
            break;
          end
          // Clock enable low stands for an absent edge: nothing moves
          ce <= ($urandom % 4) != 0;
          out_ready <= ($urandom % 100) >= busy;
          @(posedge aclk);
          if (ce && out_valid && out_ready) begin
            chk_smp(expq.size() ? expq.pop_front() : 16'hXXXX, out_data);
          end
        end
        out_ready <= 1'b0;
        ce <= 1'b1;
      end
    join
  endtask

  task automatic done(input string n);
    $display("test %s finished, mismatches so far %0d", n, n_errors);
  endtask

  initial begin
    logic [31:0] d;
    logic [2:0] c;
    logic [2:0] c3;
    int k;
    logic [9:0] a;
    void'($urandom(42169));
    byp = 3'b000;
    sh = 3'b000;
    up = 3'b000;
    do_reset();
    for (int i = 0; i < 3; i++) begin
      a = ba(8'(`IDX_FIRST_CTRL + i));
      rd("ctrl default", a, 32'h0, `RESP_OKAY);
    end
    rd("part id", ba(`IDX_PART_ID), {24'h0, ID_CODE}, `RESP_OKAY);
    rd("status", ba(`IDX_STATUS), 32'h00000003, `RESP_OKAY);
    done("defaults");
    for (int i = 0; i < 3; i++) begin
      d = {24'($urandom), 8'($urandom) & (i == 0 ? 8'h07 : 8'h7F)};
      a = ba(8'(`IDX_FIRST_CTRL + i));
      wr(a, d, 4'hF, `RESP_OKAY);
      rd("ctrl rw", a, {24'h0, d[7:0]}, `RESP_OKAY);
      wr(a, ~d, 4'hE, `RESP_OKAY);
      rd("ctrl no strobe", a, {24'h0, d[7:0]}, `RESP_OKAY);
    end
    wr(ba(`IDX_PART_ID), 32'h000000FF, 4'hF, `RESP_OKAY);
    rd("part id", ba(`IDX_PART_ID), {24'h0, ID_CODE}, `RESP_OKAY);
    wr(ba(8'h21), 32'h00000001, 4'hF, `RESP_DECERR);
    rd("unmapped", ba(8'h21), 32'h0, `RESP_DECERR);
    rd("unmapped", ba(8'h1B), 32'h0, `RESP_DECERR);
    done("registers");
    for (k = 0; k < 8; k++) begin
      c = 3'(k);
      c3 = 3'(k + 3);
      do_reset();
      rd("ctrl after reset", ba(`IDX_THIRD_CTRL), 32'h0, `RESP_OKAY);
      byp = (k < 4) ? 3'b000 : (k == 7) ? 3'b111 : 3'(1 << (k - 4));
      sh = {c3[2], c[2], c[1]};
      up = {c3[0], c[0], c[0]};
      wr(ba(`IDX_FIRST_CTRL), {29'h0, c[1:0], byp[0]}, 4'hF, `RESP_OKAY);
      // Low three mode bits random: unlisted codes fall to the listed group
      wr(ba(`IDX_SECOND_CTRL), {25'h0, c, 3'($urandom), byp[1]}, 4'hF,
         `RESP_OKAY);
      wr(ba(`IDX_THIRD_CTRL), {25'h0, c3, c3, byp[2]}, 4'hF, `RESP_OKAY);
      stream(12, 30);
      rd("status", ba(`IDX_STATUS), {30'h0, 2'(3 - $countones(byp))},
         `RESP_OKAY);
    end
    done("modes");
    do_reset();
    byp = 3'b000;
    sh = 3'b000;
    up = 3'b000;
    k = 0;
    in_valid <= 1'b1;
    in_data <= 16'($urandom) & 16'hFFF8;
    for (int i = 0; i < 60 && k < 4; i++) begin
      @(posedge aclk);
      if (in_ready) begin
        model_in(in_data);
        in_data <= 16'($urandom) & 16'hFFF8;
        k = 0;
      end else begin
        k++;
      end
    end
    in_valid <= 1'b0;
    rd("fill status", ba(`IDX_STATUS), 32'h00000023, `RESP_OKAY);
    stream(0, 40);
    rd("drain status", ba(`IDX_STATUS), 32'h00000003, `RESP_OKAY);
    done("buffer");
    close_out();
  end

  // Whole run needs a few thousand cycles; this allows about sixty thousand
  initial begin
    #3000000;
    $display("watchdog expired");
    n_errors++;
    close_out();
  end
endmodule
